// ===== pkg/io_port_pkg.sv
// constants shared by the pin group port, its checker and its bench
// assumes one 100 MHz bus clock and 32-bit register words
//
// Summary of operation
// - reset leaves pins input, buffers and pulls off
// - keeps working in sleep while clocked
// - bus clock gated upstream, needed for access
// - local bus beats peripheral bus, one-cycle stall
// - debug halt freezes nothing
// - write guard blocks writes to writable registers
// - debugger writes bypass the write guard
// - analog selection disables digital pad features
// - secured pins reachable only by secure accesses
// - non-secure toggle access only on non-secured pins
// - toggle register inverts written pins' drive level
// - zero bits in toggle write change nothing
// - toggles show in drive, set, clear views
// - 32-pin groups, copies every 0x80 from 0x00
package io_port_pkg;

	localparam int PIN_W   = 32;
	localparam int GRP_LSB = 7;
	localparam int OP_LSB  = 2;
	localparam int OP_MSB  = 3;

	localparam logic [6:0] OFF_BANK_M   = 7'h73;

	localparam logic [6:0] OFF_DIR      = 7'h00;
	localparam logic [6:0] OFF_OUT      = 7'h10;
	localparam logic [6:0] OFF_FLIP_MASK = 7'h1C;
	localparam logic [6:0] OFF_IN       = 7'h20;
	localparam logic [6:0] OFF_INEN     = 7'h24;
	localparam logic [6:0] OFF_PULLEN   = 7'h28;
	localparam logic [6:0] OFF_ANALOG   = 7'h2C;
	localparam logic [6:0] OFF_TRUST    = 7'h30;

	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_CLR   = 2'h1;
	localparam logic [1:0] OP_SET   = 2'h2;
	localparam logic [1:0] OP_TGL   = 2'h3;

	localparam logic [PIN_W-1:0] RST_ZERO  = 32'h0000_0000;
	localparam logic [PIN_W-1:0] RST_TRUST = 32'h0000_0000;
	localparam logic [PIN_W-1:0] ALL_ONES  = 32'hFFFF_FFFF;

	localparam int PPROT_NS = 1;

	typedef enum logic {APB_IDLE, APB_RESP} apb_state_t;

endpackage

// ===== src/pin_pad_ctrl.sv
// one pad slice: registered pad controls and a synchronised input
// assumes the pad pin is asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module pin_pad_ctrl
(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic dir,
	input  wire logic level,
	input  wire logic in_en,
	input  wire logic pull_en,
	input  wire logic analog,
	input  wire logic pad_in,
	output var  logic pad_out_q,
	output var  logic pad_oe_q,
	output var  logic pad_ie_q,
	output var  logic pad_pull_q,
	output var  logic in_val_q
);

	logic sync1_q;
	logic sync2_q;
	logic oe_d;
	logic ie_d;
	logic pull_d;

	// analog use strips every digital feature off the pad
	assign oe_d   = dir & ~analog;
	assign ie_d   = in_en & ~analog;
	assign pull_d = pull_en & ~dir & ~analog;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pad_out_q  <= 1'b0;
			pad_oe_q   <= 1'b0;
			pad_ie_q   <= 1'b0;
			pad_pull_q <= 1'b0;
			sync1_q    <= 1'b0;
			sync2_q    <= 1'b0;
			in_val_q   <= 1'b0;
		end
		else
		begin
			pad_out_q  <= level;
			pad_oe_q   <= oe_d;
			pad_ie_q   <= ie_d;
			pad_pull_q <= pull_d;
			sync1_q    <= pad_in;
			sync2_q    <= sync1_q;
			in_val_q   <= sync2_q & pad_ie_q;
		end
	end

endmodule
`default_nettype wire

// ===== src/io_pin_group_port.sv
// pin group port: register file on the peripheral bus and the local bus,
// with per-pin pad slices
// assumes the clock manager gates ref_clk; the core drives both buses
`timescale 1ns/1ps
`default_nettype none
module io_pin_group_port
	import io_port_pkg::*;
#(
	parameter int GROUPS = 1,
	parameter int ADDR_W = 12
)
(
	input  wire logic                    ref_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ADDR_W-1:0]       paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [2:0]              pprot,
	output var  logic [31:0]             prdata,
	output var  logic                    pready,
	output var  logic                    pslverr,
	input  wire logic                    debugger_access,
	input  wire logic                    write_guard_lock,
	input  wire logic                    iob_valid,
	input  wire logic                    iob_write,
	input  wire logic [ADDR_W-1:0]       iob_addr,
	input  wire logic [31:0]             iob_wdata,
	input  wire logic                    iob_pin_trust_attribution,
	output var  logic [31:0]             iob_rdata,
	input  wire logic [GROUPS*PIN_W-1:0] pad_in,
	output var  logic [GROUPS*PIN_W-1:0] pad_out,
	output var  logic [GROUPS*PIN_W-1:0] pad_oe,
	output var  logic [GROUPS*PIN_W-1:0] pad_in_en,
	output var  logic [GROUPS*PIN_W-1:0] pad_pull_en
);

	localparam int GRP_W = ADDR_W - GRP_LSB;

	generate
		if (GROUPS < 1 || ADDR_W <= GRP_LSB || GROUPS > (1 << (ADDR_W - GRP_LSB)))
		begin : g_bad_cfg
			$error("group count does not fit the address width");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// register state: pin registers one copy per group, bus state shared

	logic [PIN_W-1:0] dir_q    [GROUPS];
	logic [PIN_W-1:0] level_q  [GROUPS];
	logic [PIN_W-1:0] inen_q   [GROUPS];
	logic [PIN_W-1:0] pullen_q [GROUPS];
	logic [PIN_W-1:0] analog_q [GROUPS];
	logic [PIN_W-1:0] trust_q  [GROUPS];

	apb_state_t       apb_st_q;
	apb_state_t       apb_st_d;
	logic [31:0]      prdata_q;
	logic             pslverr_q;
	logic [31:0]      iob_rdata_q;

	logic [GROUPS*PIN_W-1:0] pin_val;
	logic [GROUPS*PIN_W-1:0] dir_flat;
	logic [GROUPS*PIN_W-1:0] level_flat;
	logic [GROUPS*PIN_W-1:0] inen_flat;
	logic [GROUPS*PIN_W-1:0] pullen_flat;
	logic [GROUPS*PIN_W-1:0] analog_flat;

	////////////////////////////////////////////////////////////////////////
	// one bit-wise operation shared by plain, clear, set and flip views

	function automatic logic [PIN_W-1:0] apply_op
	(
		input logic [1:0]       op,
		input logic [PIN_W-1:0] old,
		input logic [PIN_W-1:0] data,
		input logic [PIN_W-1:0] allow
	);
		logic [PIN_W-1:0] m;
		m = data & allow;
		unique case (op)
			OP_WRITE: apply_op = (old & ~allow) | m;
			OP_CLR:   apply_op = old & ~m;
			OP_SET:   apply_op = old | m;
			OP_TGL:   apply_op = old ^ m;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// arbitration: the local bus wins, the peripheral bus waits a cycle

	logic              apb_go;
	logic              acc_valid;
	logic              acc_write;
	logic [ADDR_W-1:0] acc_addr;
	logic [31:0]       acc_wdata;
	logic              acc_pin_trust_attribution;
	logic              acc_debug;

	// a peripheral access colliding with the local bus is simply held
	assign apb_go     = psel & penable & (apb_st_q == APB_IDLE) & ~iob_valid;
	assign acc_valid  = iob_valid | apb_go;
	assign acc_write  = iob_valid ? iob_write : pwrite;
	assign acc_addr   = iob_valid ? iob_addr : paddr;
	assign acc_wdata  = iob_valid ? iob_wdata : pwdata;
	assign acc_pin_trust_attribution = iob_valid ? iob_pin_trust_attribution : pprot[PPROT_NS];
	assign acc_debug  = ~iob_valid & debugger_access;

	////////////////////////////////////////////////////////////////////////
	// address decode

	logic [GRP_W-1:0] acc_grp;
	logic [6:0]       acc_off;
	logic [6:0]       acc_bank;
	logic             grp_ok;
	int unsigned      gi;

	assign acc_grp  = acc_addr[ADDR_W-1:GRP_LSB];
	assign acc_off  = acc_addr[GRP_LSB-1:0];
	assign acc_bank = acc_off & OFF_BANK_M;
	assign grp_ok   = (32'(acc_grp) < GROUPS);
	assign gi       = grp_ok ? 32'(acc_grp) : 0;

	logic hit_dir;
	logic hit_out;
	logic hit_in;
	logic hit_inen;
	logic hit_pullen;
	logic hit_analog;
	logic hit_trust;
	logic mapped;

	assign hit_dir    = (acc_bank == OFF_DIR);
	assign hit_out    = (acc_bank == OFF_OUT);
	assign hit_in     = (acc_off == OFF_IN);
	assign hit_inen   = (acc_off == OFF_INEN);
	assign hit_pullen = (acc_off == OFF_PULLEN);
	assign hit_analog = (acc_off == OFF_ANALOG);
	assign hit_trust  = (acc_off == OFF_TRUST);
	assign mapped     = grp_ok & (hit_dir | hit_out | hit_in | hit_inen
	                    | hit_pullen | hit_analog | hit_trust);

	////////////////////////////////////////////////////////////////////////
	// protection and security masks

	logic [PIN_W-1:0] cur_trust;
	logic             guard_block;
	logic             trust_deny;
	logic [PIN_W-1:0] allow;
	logic             wr_ok;
	logic             acc_err;
	logic [1:0]       acc_op;

	assign cur_trust   = trust_q[gi];
	// debugger writes are never guarded
	assign guard_block = write_guard_lock & ~acc_debug;
	// only secure code may move a pin between the trust classes
	assign trust_deny  = hit_trust & acc_pin_trust_attribution;
	assign allow       = acc_pin_trust_attribution ? cur_trust : ALL_ONES;
	assign wr_ok       = acc_valid & acc_write & mapped & ~hit_in
	                     & ~guard_block & ~trust_deny;
	assign acc_err     = ~mapped | (acc_write & (guard_block | trust_deny));
	assign acc_op      = (hit_dir | hit_out) ? acc_off[OP_MSB:OP_LSB] : OP_WRITE;

	////////////////////////////////////////////////////////////////////////
	// read data

	logic [PIN_W-1:0] old_val;
	logic [PIN_W-1:0] new_val;
	logic [PIN_W-1:0] rd_raw;
	logic [PIN_W-1:0] rd_word;

	assign old_val = hit_dir    ? dir_q[gi]    :
	                 hit_out    ? level_q[gi]  :
	                 hit_inen   ? inen_q[gi]   :
	                 hit_pullen ? pullen_q[gi] :
	                 hit_analog ? analog_q[gi] :
	                 hit_trust  ? trust_q[gi]  : RST_ZERO;

	assign new_val = apply_op(acc_op, old_val, acc_wdata, allow);

	// every view of the drive level reads the same flop, so flips show in all
	assign rd_raw  = hit_in ? pin_val[gi*PIN_W +: PIN_W] : old_val;
	assign rd_word = (acc_pin_trust_attribution & ~hit_trust) ? (rd_raw & cur_trust) : rd_raw;

	////////////////////////////////////////////////////////////////////////
	// register update; no halt or sleep input, so nothing ever freezes

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			for (int g = 0; g < GROUPS; g++)
			begin
				dir_q[g]    <= RST_ZERO;
				level_q[g]  <= RST_ZERO;
				inen_q[g]   <= RST_ZERO;
				pullen_q[g] <= RST_ZERO;
				analog_q[g] <= RST_ZERO;
				trust_q[g]  <= RST_TRUST;
			end
		end
		else if (wr_ok)
		begin
			for (int g = 0; g < GROUPS; g++)
			begin
				if (gi == g)
				begin
					if (hit_dir)
						dir_q[g] <= new_val;
					if (hit_out)
						level_q[g] <= new_val;
					if (hit_inen)
						inen_q[g] <= new_val;
					if (hit_pullen)
						pullen_q[g] <= new_val;
					if (hit_analog)
						analog_q[g] <= new_val;
					if (hit_trust)
						trust_q[g] <= new_val;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peripheral bus handshake: ready is registered, so one wait state
	// always, and one more when the local bus takes the cycle

	always_comb
	begin
		apb_st_d = apb_st_q;
		unique case (apb_st_q)
			APB_IDLE: if (apb_go) apb_st_d = APB_RESP;
			APB_RESP: apb_st_d = APB_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			apb_st_q  <= APB_IDLE;
			prdata_q  <= RST_ZERO;
			pslverr_q <= 1'b0;
		end
		else
		begin
			apb_st_q <= apb_st_d;
			if (apb_go)
			begin
				prdata_q  <= acc_write ? RST_ZERO : rd_word;
				pslverr_q <= acc_err;
			end
			else
			begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// local bus read data lands the cycle after the request
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			iob_rdata_q <= RST_ZERO;
		else if (iob_valid & ~iob_write)
			iob_rdata_q <= rd_word;
	end

	assign prdata    = prdata_q;
	assign pready    = (apb_st_q == APB_RESP);
	assign pslverr   = pslverr_q;
	assign iob_rdata = iob_rdata_q;

	////////////////////////////////////////////////////////////////////////
	// pad slices

	genvar gg;
	genvar pp;
	generate
		for (gg = 0; gg < GROUPS; gg++)
		begin : g_flat
			assign dir_flat[gg*PIN_W +: PIN_W]    = dir_q[gg];
			assign level_flat[gg*PIN_W +: PIN_W]  = level_q[gg];
			assign inen_flat[gg*PIN_W +: PIN_W]   = inen_q[gg];
			assign pullen_flat[gg*PIN_W +: PIN_W] = pullen_q[gg];
			assign analog_flat[gg*PIN_W +: PIN_W] = analog_q[gg];
		end
		for (pp = 0; pp < GROUPS*PIN_W; pp++)
		begin : g_pad
			pin_pad_ctrl u_pad
			(
				.ref_clk    (ref_clk),
				.sys_rst    (sys_rst),
				.dir        (dir_flat[pp]),
				.level      (level_flat[pp]),
				.in_en      (inen_flat[pp]),
				.pull_en    (pullen_flat[pp]),
				.analog     (analog_flat[pp]),
				.pad_in     (pad_in[pp]),
				.pad_out_q  (pad_out[pp]),
				.pad_oe_q   (pad_oe[pp]),
				.pad_ie_q   (pad_in_en[pp]),
				.pad_pull_q (pad_pull_en[pp]),
				.in_val_q   (pin_val[pp])
			);
		end
	endgenerate

endmodule
`default_nettype wire

// ===== bench/cpu_bus_model.sv
// cpu side model: a peripheral bus master and a local bus master
// assumes the bench calls apb and lb, both possibly at once
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
(
	input  wire logic		ref_clk,
	input  wire logic [31:0]	prdata,
	input  wire logic		pready,
	input  wire logic		pslverr,
	output var  logic		psel,
	output var  logic		penable,
	output var  logic		pwrite,
	output var  logic [11:0]	paddr,
	output var  logic [31:0]	pwdata,
	output var  logic [2:0]	pprot,
	output var  logic		debugger_access,
	output var  logic		iob_valid,
	output var  logic		iob_write,
	output var  logic [11:0]	iob_addr,
	output var  logic [31:0]	iob_wdata,
	output var  logic		iob_pin_trust_attribution
);
initial
begin
	{psel, penable, pwrite, debugger_access, pprot, paddr, pwdata} = '0;
	{iob_valid, iob_write, iob_pin_trust_attribution, iob_addr, iob_wdata} = '0;
end
// released address and data lines are inverted so a stale value cannot pass for a live one
task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
	input logic ns, input logic dg, output logic [31:0] q, output logic e);
	@(posedge ref_clk);
	{psel, pwrite, paddr, pwdata, pprot, debugger_access} <= {1'b1, w, a, d, 1'b0, ns, 1'b0, dg};
	@(posedge ref_clk);
	penable <= 1'b1;
	@(posedge ref_clk);
	// a port that never answers hangs here until the bench watchdog fails the run
	while (pready !== 1'b1)
		@(posedge ref_clk);
	q = prdata;
	e = pslverr;
	{psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
endtask
task lb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ns);
	@(posedge ref_clk);
	{iob_valid, iob_write, iob_addr, iob_wdata, iob_pin_trust_attribution} <= {1'b1, w, a, d, ns};
	@(posedge ref_clk);
	{iob_valid, iob_addr, iob_wdata} <= {1'b0, ~a, ~d};
endtask
endmodule
`default_nettype wire

// ===== bench/io_pin_group_port_chk.sv
// assertions on the pin group port's top-level ports
// assumes binding to the top module, group 0 at offset 0x00
`timescale 1ns/1ps
`default_nettype none
module io_pin_group_port_chk
	import io_port_pkg::*;
#(parameter int GROUPS = 1, parameter int ADDR_W = 12)
(
	input  wire logic				ref_clk,
	input  wire logic				sys_rst,
	input  wire logic				psel,
	input  wire logic				penable,
	input  wire logic				pready,
	input  wire logic				write_guard_lock,
	input  wire logic				iob_valid,
	input  wire logic				iob_write,
	input  wire logic				iob_pin_trust_attribution,
	input  wire logic [ADDR_W-1:0]		iob_addr,
	input  wire logic [31:0]			iob_wdata,
	input  wire logic [31:0]			iob_rdata,
	input  wire logic [GROUPS*PIN_W-1:0]	pad_out,
	input  wire logic [GROUPS*PIN_W-1:0]	pad_oe,
	input  wire logic [GROUPS*PIN_W-1:0]	pad_in_en,
	input  wire logic [GROUPS*PIN_W-1:0]	pad_pull_en
);
default clocking dc @(posedge ref_clk);
endclocking
default disable iff (sys_rst);
////////////////////
// pads follow a local write two edges later: register, then pad flop
wire flip_wr = iob_valid && iob_write && iob_addr == ADDR_W'(OFF_FLIP_MASK);
chk_rst_pads: assert property (disable iff (1'b0)
	sys_rst |=> !(pad_oe | pad_in_en | pad_pull_en)) else $error("pads on after reset");
chk_pready_pulse: assert property (pready |=> !pready)
	else $error("pready too long");
chk_apb_answer: assert property (psel && $rose(penable) && !iob_valid |=> pready)
	else $error("peripheral answer late");
chk_local_first: assert property (psel && penable && iob_valid && !pready |=> !pready)
	else $error("peripheral access not stalled");
chk_pull_input: assert property (!(pad_pull_en & pad_oe))
	else $error("pull on a driven pin");
chk_flip_local: assert property (flip_wr && !iob_pin_trust_attribution && !write_guard_lock
	|-> ##2 pad_out[31:0] == ($past(pad_out[31:0]) ^ $past(iob_wdata, 2))) else $error("bad flip");
chk_zero_flip: assert property (flip_wr && iob_wdata == '0 |-> ##2 $stable(pad_out))
	else $error("zero flip moved pins");
chk_guard_local: assert property (flip_wr && write_guard_lock |-> ##2 $stable(pad_out))
	else $error("guarded write moved pins");
chk_rdata_hold: assert property (!(iob_valid && !iob_write) |=> $stable(iob_rdata))
	else $error("local read data moved");
cover property (psel && penable && iob_valid);
cover property (flip_wr && write_guard_lock);
cover property (flip_wr && iob_pin_trust_attribution);
endmodule
bind io_pin_group_port io_pin_group_port_chk #(.GROUPS(GROUPS), .ADDR_W(ADDR_W))
	i_io_pin_group_port_chk (.ref_clk, .sys_rst, .psel, .penable, .pready, .write_guard_lock,
	.iob_valid, .iob_write, .iob_pin_trust_attribution, .iob_addr, .iob_wdata, .iob_rdata, .pad_out,
	.pad_oe, .pad_in_en, .pad_pull_en);
`default_nettype wire

// ===== bench/io_pin_group_port_tb.sv
// self-checking bench for the pin group port with two groups
// assumes the cpu bus model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
	begin total_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD %0t got %h want %h", $time, (a), (b)); end end
module io_pin_group_port_tb
	import io_port_pkg::*;
;
logic		ref_clk = 1'b0, sys_rst = 1'b1, write_guard_lock = 1'b0;
logic		psel, penable, pwrite, pready, pslverr, debugger_access, e;
logic		iob_valid, iob_write, iob_pin_trust_attribution;
logic [11:0]	paddr, iob_addr;
logic [2:0]	pprot;
logic [31:0]	pwdata, prdata, iob_wdata, iob_rdata, tr, f, q, allow;
logic [31:0]	lvl [2] = '{32'h0, 32'h0};
logic [63:0]	pad_in, pad_out, pad_oe, pad_in_en, pad_pull_en;
int		seed = 32141, errors = 0, total_checks = 0, i, g;
io_pin_group_port #(.GROUPS(2), .ADDR_W(12)) i_io_pin_group_port (.ref_clk, .sys_rst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata, .pready, .pslverr,
	.debugger_access, .write_guard_lock, .iob_valid, .iob_write, .iob_addr, .iob_wdata,
	.iob_pin_trust_attribution, .iob_rdata, .pad_in, .pad_out, .pad_oe, .pad_in_en, .pad_pull_en);
cpu_bus_model i_cpu_bus_model (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pprot, .debugger_access, .iob_valid, .iob_write,
	.iob_addr, .iob_wdata, .iob_pin_trust_attribution);
always #5 ref_clk = ~ref_clk;
////////////////////
task give_verdict;
	if (errors == 0 && total_checks > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
task wr(input logic [11:0] a, input logic [31:0] d, input logic ns, input logic dg);
	i_cpu_bus_model.apb('1, a, d, ns, dg, q, e);
endtask
task rd(input logic [11:0] a, input logic ns, input logic [31:0] x);
	i_cpu_bus_model.apb('0, a, '0, ns, '0, q, e);
	`CHK(q, x)
endtask
task views(input int gp);
	for (int k = 0; k < 3; k++)
		rd(12'(gp * 128 + 16 + k * 4), '0, lvl[gp]);
	`CHK(pad_out[gp*32 +: 32], lvl[gp])
endtask
initial
begin
	pad_in <= {$random(seed), $random(seed)};
	repeat (10) @(posedge ref_clk);
	sys_rst <= 1'b0;
	@(posedge ref_clk);
	`CHK(pad_oe | pad_in_en | pad_pull_en | pad_out, 64'h0)
	rd(12'h01C, '0, 32'h0);
	tr = $random(seed);
	wr(12'h030, tr, '0, '0);
	wr(12'h030, ALL_ONES, '1, '0);
	`CHK(e, 1'b1)
	wr(12'h000, ALL_ONES, '0, '0);
	for (i = 0; i < 8; i++)
	begin
		g = i % 2;
		f = (i == 2) ? 32'h0 : $random(seed);
		allow = (i / 2 == 1) ? (g ? 32'h0 : tr) : ALL_ONES;
		if (i / 2 == 3)
		begin
			write_guard_lock <= 1'b1;
			i_cpu_bus_model.lb('1, 12'(g * 128 + 28), f, '0);
			wr(12'(g * 128 + 28), f, '0, g[0]);
			`CHK(e, !g[0])
			write_guard_lock <= 1'b0;
			allow = g ? ALL_ONES : 32'h0;
		end
		else if (i / 2 == 0)
			wr(12'(g * 128 + 28), f, '0, '0);
		else
			i_cpu_bus_model.lb('1, 12'(g * 128 + 28), f, i / 2 == 1);
		lvl[g] = lvl[g] ^ (f & allow);
		views(g);
	end
	f = $random(seed);
	fork
		wr(12'h09C, f, '0, '0);
		begin
			@(posedge ref_clk);
			i_cpu_bus_model.lb('1, 12'h01C, ~f, '0);
		end
	join
	lvl = '{lvl[0] ^ ~f, lvl[1] ^ f};
	for (g = 0; g < 2; g++) views(g);
	`CHK(pad_oe[31:0], ALL_ONES)
	wr(12'h0A8, ALL_ONES, '0, '0);
	wr(12'h024, ALL_ONES, '0, '0);
	`CHK(pad_pull_en, {ALL_ONES, 32'h0})
	rd(12'h020, '0, pad_in[31:0]);
	wr(12'h02C, ALL_ONES, '0, '0);
	i_cpu_bus_model.lb('0, 12'h010, '0, '1);
	// local read data lands on the edge that takes the request, so it is there one edge later
	@(posedge ref_clk);
	`CHK(iob_rdata, lvl[0] & tr)
	`CHK(pad_oe[31:0] | pad_in_en[31:0], 32'h0)
	rd(12'h020, '0, 32'h0);
	// a second reset in mid-run must clear what the scenarios set up
	sys_rst <= 1'b1;
	repeat (2) @(posedge ref_clk);
	sys_rst <= 1'b0;
	@(posedge ref_clk);
	`CHK(pad_out | pad_oe | pad_in_en | pad_pull_en, 64'h0)
	rd(12'h0A8, '0, 32'h0);
	give_verdict;
end
initial
begin
	repeat (5000) @(posedge ref_clk);
	errors++;
	give_verdict;
end
endmodule
`default_nettype wire
